// File: verilog/sync_serial_port.sv
// Functional notes
// - Enabled master drives clock at idle polarity
// - Master data output holds last bit
// - Master starts first bit on next tick
// - Shift out one edge, latch other edge
// - Frame end copies to receive buffer, pulses
// - Slave presents first bit on load immediately
// - Slave busy only from first clock edge
// - Every frame sent also yields received frame
// - Own outgoing bits captured on data input
// - Reloaded buffer continues with no gap
// - Sixteen-bit down-counter with reload
// - Disabled: baud register is reload value
// - Enabled: baud register reads live count
// - Enable loads timer and starts counting
// - Rate is clock over two times reload+1
// - Width field plus one bits, zero reserved
// - Bit order select, data right-aligned
// - Polarity sets idle, phase picks edges
// - Busy clears with receive load if empty
//
// Chosen here: the address map and the APB interface to the registers.
module sync_serial_port
    import sync_port_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic generated_shift_clock_in,
    output logic generated_shift_clock_out,
    output logic generated_shift_clock_oe,
    input wire logic master_out_slave_in_line_in,
    output logic master_out_slave_in_line_out,
    output logic master_out_slave_in_line_oe,
    input wire logic master_in_slave_out_line_in,
    output logic master_in_slave_out_line_out,
    output logic master_in_slave_out_line_oe,
    output logic receive_irq_line,
    output logic transmit_irq_line
);
    // ****************************************
    // Declarations
    // ****************************************
    logic en_ff, ms_ff, po_ff, ph_ff, hb_ff, drv_ff;
    logic [3:0] bm_ff;
    logic [15:0] reload_ff, txb_ff, rxb_ff, sr_ff;
    logic txfull_ff, busy_ff;
    shift_state_e st_ff;
    logic [4:0] edge_ff;
    logic sclk_ff, dout_ff;
    logic sync1_ff, sync2_ff, sync3_ff;
    logic rx_irq_ff, tx_irq_ff;
    logic sclk_oe_ff, mosi_oe_ff, miso_oe_ff;
    logic [31:0] prdata_ff;
    logic pready_ff, pslverr_ff;
    logic [31:0] rd_data;
    logic mapped;
    baud_if bif ();

    // First bit to send: MSB of the selected width or bit 0
    function automatic logic first_bit(input logic [15:0] v, input logic hb,
                                       input logic [3:0] bm);
        first_bit = hb ? v[bm] : v[0];
    endfunction : first_bit

    // Shift one bit in; data stays right-aligned in either order
    function automatic logic [15:0] shift_in(input logic [15:0] v, input logic b,
                                             input logic hb, input logic [3:0] bm);
        logic [15:0] r;
        r = '0;
        if (hb) begin
            r = {v[14:0], b};
        end else begin
            r = {1'b0, v[15:1]};
            r[bm] = b;
        end
        shift_in = r;
    endfunction : shift_in

    // ****************************************
    // Baudrate generator
    // ****************************************
    assign bif.run = en_ff;
    assign bif.reload = reload_ff;

    baud_gen u_baud (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .bus(bif.gen)
    );

    // ****************************************
    // APB slave
    // ****************************************
    wire setup = psel & ~penable;
    wire wr_acc = psel & penable & pready_ff & pwrite;
    // Read mux; the baud word shows the live count only while running
    always_comb begin
        rd_data = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr)
            OFS_CTRL: begin
                rd_data[BIT_EN] = en_ff;
                rd_data[BIT_MS] = ms_ff;
                rd_data[BIT_BUSY] = busy_ff;
                rd_data[BIT_TXFULL] = txfull_ff;
                rd_data[BIT_DRV] = drv_ff;
                rd_data[BIT_PO] = po_ff;
                rd_data[BIT_PH] = ph_ff;
                rd_data[BIT_HB] = hb_ff;
                rd_data[BM_LSB +: 4] = bm_ff;
            end
            OFS_BAUD: rd_data[15:0] = en_ff ? bif.count : reload_ff;
            OFS_TXB: rd_data[15:0] = txb_ff;
            OFS_RXB: rd_data[15:0] = rxb_ff;
            default: mapped = 1'b0;
        endcase
    end
    // One wait-free access phase: answer is prepared during setup
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= setup;
            pslverr_ff <= setup & ~mapped;
            if (setup) begin
                prdata_ff <= pwrite ? 32'h0000_0000 : rd_data;
            end
        end
    end
    // Control word: polarity, phase, bit order and width only change while disabled
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            en_ff <= 1'b0;
            ms_ff <= 1'b0;
            po_ff <= 1'b0;
            ph_ff <= 1'b0;
            hb_ff <= 1'b0;
            drv_ff <= 1'b0;
            bm_ff <= WIDTH_RESET;
        end else if (wr_acc && paddr == OFS_CTRL) begin
            if (!en_ff) begin
                po_ff <= pwdata[BIT_PO];
                ph_ff <= pwdata[BIT_PH];
                hb_ff <= pwdata[BIT_HB];
                bm_ff <= pwdata[BM_LSB +: 4];
            end
            en_ff <= pwdata[BIT_EN];
            ms_ff <= pwdata[BIT_MS];
            drv_ff <= pwdata[BIT_DRV];
        end
    end
    // Reload register; writes while enabled are dropped to protect the count
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reload_ff <= BAUD_RESET;
        end else if (wr_acc && paddr == OFS_BAUD && !en_ff) begin
            reload_ff <= pwdata[15:0];
        end
    end

    // ****************************************
    // Shift engine
    // ****************************************
    // Slave clock is brought into the module clock domain before edge detection
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            sync3_ff <= 1'b0;
        end else begin
            sync1_ff <= generated_shift_clock_in;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end
    wire slave_edge = en_ff & ~ms_ff & (sync2_ff ^ sync3_ff);
    wire master_step = en_ff & ms_ff & (st_ff == ST_RUN) & bif.tick;
    wire master_start = en_ff & ms_ff & (st_ff == ST_LOADED) & bif.tick;
    wire step = master_step | slave_edge;
    wire last_edge = (edge_ff == {bm_ff, 1'b1});
    wire is_latch = ph_ff ? edge_ff[0] : ~edge_ff[0];
    wire is_present = ph_ff ? ~edge_ff[0] : (edge_ff[0] & ~last_edge);
    wire frame_end = step & last_edge;
    wire load_now = en_ff & txfull_ff & (((st_ff == ST_IDLE) & ~step) | frame_end);
    // Master listens on its input line, slave on the master output line
    wire din = ms_ff ? master_in_slave_out_line_in : master_out_slave_in_line_in;
    // State and edge counter; a reload at frame end goes straight on
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff <= ST_IDLE;
            edge_ff <= EDGE_RESET;
        end else if (!en_ff) begin
            st_ff <= ST_IDLE;
            edge_ff <= EDGE_RESET;
        end else begin
            case (st_ff)
                ST_IDLE, ST_LOADED, ST_RUN: begin
                    if (frame_end) begin
                        st_ff <= txfull_ff ? ST_RUN : ST_IDLE;
                        edge_ff <= EDGE_RESET;
                    end else if (step) begin
                        st_ff <= ST_RUN;
                        edge_ff <= 5'(edge_ff + EDGE_ONE);
                    end else if (master_start) begin
                        st_ff <= ST_RUN;
                        edge_ff <= ph_ff ? EDGE_ONE : EDGE_RESET;
                    end else if (load_now) begin
                        st_ff <= ST_LOADED;
                    end
                end
                default: begin
                    st_ff <= ST_IDLE;
                    edge_ff <= EDGE_RESET;
                end
            endcase
        end
    end
    // Shift register: latch edges move the line bit in as the old bit leaves
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sr_ff <= TXB_RESET;
        end else if (load_now) begin
            sr_ff <= txb_ff;
        end else if (step && is_latch) begin
            sr_ff <= shift_in(sr_ff, din, hb_ff, bm_ff);
        end
    end
    // Receive buffer always updated, valid data or not
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rxb_ff <= TXB_RESET;
        end else if (frame_end) begin
            rxb_ff <= ph_ff ? shift_in(sr_ff, din, hb_ff, bm_ff) : sr_ff;
        end
    end
    // Transmit buffer and its full flag; a new write beats the move out
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            txb_ff <= TXB_RESET;
            txfull_ff <= 1'b0;
        end else if (wr_acc && paddr == OFS_TXB) begin
            txb_ff <= pwdata[15:0];
            txfull_ff <= 1'b1;
        end else if (load_now) begin
            txfull_ff <= 1'b0;
        end
    end
    // Data output; held between frames so the line never glitches
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dout_ff <= 1'b0;
        end else if (load_now && (!ms_ff || (frame_end && !ph_ff))) begin
            dout_ff <= first_bit(txb_ff, hb_ff, bm_ff);
        end else if (master_start || (step && is_present && !frame_end)) begin
            dout_ff <= first_bit(sr_ff, hb_ff, bm_ff);
        end
    end
    // Busy: a slave waits for the first clock edge before showing it
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_ff <= 1'b0;
        end else if (!en_ff) begin
            busy_ff <= 1'b0;
        end else if (frame_end) begin
            busy_ff <= txfull_ff;
        end else if (step || master_start) begin
            busy_ff <= 1'b1;
        end
    end
    // Master clock: idle level when not shifting, toggled on each running tick and, with phase set, on the start tick
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_ff <= 1'b0;
        end else if (!en_ff || !ms_ff || st_ff == ST_IDLE) begin
            sclk_ff <= po_ff;
        end else if (master_step || (master_start && ph_ff)) begin
            sclk_ff <= ~sclk_ff;
        end
    end
    // Interrupt request pulses and pin enables
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_irq_ff <= 1'b0;
            tx_irq_ff <= 1'b0;
            sclk_oe_ff <= 1'b0;
            mosi_oe_ff <= 1'b0;
            miso_oe_ff <= 1'b0;
        end else begin
            rx_irq_ff <= frame_end;
            tx_irq_ff <= load_now;
            sclk_oe_ff <= en_ff & ms_ff;
            mosi_oe_ff <= en_ff & ms_ff;
            miso_oe_ff <= en_ff & ~ms_ff & drv_ff;
        end
    end
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign generated_shift_clock_out = sclk_ff;
    assign generated_shift_clock_oe = sclk_oe_ff;
    assign master_out_slave_in_line_out = dout_ff;
    assign master_out_slave_in_line_oe = mosi_oe_ff;
    assign master_in_slave_out_line_out = dout_ff;
    assign master_in_slave_out_line_oe = miso_oe_ff;
    assign receive_irq_line = rx_irq_ff;
    assign transmit_irq_line = tx_irq_ff;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    property p_rx_pulse;
        frame_end |=> rx_irq_ff ##1 !rx_irq_ff;
    endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("rx irq not one pulse");
    property p_busy_clear;
        (frame_end && !txfull_ff) |=> !busy_ff && (ph_ff || rxb_ff == $past(sr_ff));
    endproperty
    a_busy_clear: assert property (p_busy_clear) else $error("busy not cleared");
    property p_slave_wait;
        (!ms_ff && st_ff == ST_LOADED) |-> !busy_ff;
    endproperty
    a_slave_wait: assert property (p_slave_wait) else $error("slave busy early");
    property p_slave_first;
        (load_now && !ms_ff) |=> dout_ff == $past(first_bit(txb_ff, hb_ff, bm_ff));
    endproperty
    a_slave_first: assert property (p_slave_first) else $error("slave first bit");
    property p_master_idle_clk;
        (en_ff && ms_ff && st_ff == ST_IDLE) [*2] |-> sclk_ff == po_ff;
    endproperty
    a_master_idle_clk: assert property (p_master_idle_clk) else $error("idle level");
    property p_hold_last;
        (st_ff == ST_IDLE && $past(st_ff) == ST_IDLE && !load_now) |=> $stable(dout_ff);
    endproperty
    a_hold_last: assert property (p_hold_last) else $error("data moved in idle");
    property p_enable_load;
        $rose(en_ff) |-> bif.count == reload_ff ##1 bif.count == 16'(reload_ff - 16'h0001)
            || reload_ff == 16'h0000;
    endproperty
    a_enable_load: assert property (p_enable_load) else $error("timer not loaded");
    property p_tick_reload;
        (bif.tick && en_ff) |=> !en_ff || bif.count == reload_ff;
    endproperty
    a_tick_reload: assert property (p_tick_reload) else $error("reload missed");
    property p_master_wait;
        (ms_ff && st_ff == ST_LOADED && !bif.tick) |=> $stable(sclk_ff);
    endproperty
    a_master_wait: assert property (p_master_wait) else $error("early master clock");
    c_master_frame: cover property (ms_ff && frame_end);
    c_slave_frame: cover property (!ms_ff && frame_end);
    c_back_to_back: cover property (frame_end && txfull_ff);
endmodule : sync_serial_port

// File: verilog/sync_port_pkg.sv
package sync_port_pkg;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int DATA_W = 16;
    localparam int BAUD_W = 16;

    // ****************************************
    // Register offsets (byte addresses, one word each)
    // ****************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BAUD = 8'h04;
    localparam logic [7:0] OFS_TXB = 8'h08;
    localparam logic [7:0] OFS_RXB = 8'h0C;

    // ****************************************
    // Field positions of port_control_register
    // ****************************************
    localparam int BIT_EN = 15;
    localparam int BIT_MS = 14;
    localparam int BIT_BUSY = 12;
    localparam int BIT_TXFULL = 8;
    localparam int BIT_DRV = 7;
    localparam int BIT_PO = 6;
    localparam int BIT_PH = 5;
    localparam int BIT_HB = 4;
    localparam int BM_LSB = 0;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [15:0] BAUD_RESET = 16'h0000;
    localparam logic [15:0] TXB_RESET = 16'h0000;
    localparam logic [3:0] WIDTH_RESET = 4'h0;
    localparam logic [4:0] EDGE_RESET = 5'h00;
    localparam logic [4:0] EDGE_ONE = 5'h01;

    // ****************************************
    // Shift engine states
    // ****************************************
    typedef enum logic [1:0] {ST_IDLE, ST_LOADED, ST_RUN} shift_state_e;
endpackage : sync_port_pkg

// File: verilog/baud_if.sv
interface baud_if;
    logic run;
    logic [15:0] reload;
    logic tick;
    logic [15:0] count;
    modport gen (input run, input reload, output tick, output count);
    modport user (output run, output reload, input tick, input count);
endinterface : baud_if

// File: verilog/baud_gen.sv
module baud_gen
    import sync_port_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    baud_if.gen bus
);
    logic [BAUD_W-1:0] count_ff;

    // Down-counter: held at reload while stopped so enabling starts at once
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_ff <= BAUD_RESET;
        end else if (!bus.run) begin
            count_ff <= bus.reload;
        end else if (count_ff == '0) begin
            count_ff <= bus.reload;
        end else begin
            count_ff <= count_ff - 16'h0001;
        end
    end

    // One tick every reload+1 cycles; two ticks make one shift clock period
    assign bus.tick = bus.run & (count_ff == '0);
    assign bus.count = count_ff;
endmodule : baud_gen

// File: verif/peer_serial_model.sv
// ****************************************
// Selected peer slave, idle-low clock, data out on the leading edge
// ****************************************
module peer_serial_model (
    input wire logic sclk,
    input wire logic mosi,
    input wire logic load,
    input wire logic [15:0] word,
    input wire logic [4:0] nbits,
    output logic miso,
    output logic [15:0] got
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] sh;
    initial begin
        miso = 1'b0;
        got = 16'h0000;
        sh = 16'h0000;
    end
    // New frame: flip the line so stale data never looks valid
    always @(posedge load) begin
        sh = word;
        got = 16'h0000;
        miso = ~miso;
    end
    // Only this selected peer drives, next bit MSB first
    always @(posedge sclk) begin
        miso = sh[nbits - 5'h01];
        sh = sh << 1;
    end
    // Trailing edge takes the master's bit, every frame both ways
    always @(negedge sclk) got = {got[14:0], mosi};
endmodule : peer_serial_model

// File: verif/sync_serial_master_slave_port_tb.sv
module sync_serial_master_slave_port_tb;
    import sync_port_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LIMIT = 20000;
    localparam logic [7:0] SLAVE_RX = 8'hC3;
    logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic s_clk, s_data, loop_sel, peer_load, peer_miso;
    logic sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe, rx_irq, tx_irq;
    logic [15:0] peer_word, peer_got;
    logic [4:0] peer_nbits;
    logic sclk_q;
    int fail_count, checks_done, cyc, edges, last_rise, max_gap, min_gap;
    sync_serial_port sync_serial_port_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .generated_shift_clock_in(s_clk), .generated_shift_clock_out(sclk_out),
        .generated_shift_clock_oe(sclk_oe), .master_out_slave_in_line_in(s_data),
        .master_out_slave_in_line_out(mosi_out), .master_out_slave_in_line_oe(mosi_oe),
        .master_in_slave_out_line_in(loop_sel ? (mosi_out & peer_miso) : peer_miso),
        .master_in_slave_out_line_out(miso_out), .master_in_slave_out_line_oe(miso_oe),
        .receive_irq_line(rx_irq), .transmit_irq_line(tx_irq));
    // One master on the lines: the peer is always a slave
    peer_serial_model peer_serial_model_inst (.sclk(sclk_out), .mosi(mosi_out),
        .load(peer_load), .word(peer_word), .nbits(peer_nbits), .miso(peer_miso),
        .got(peer_got));
    // ****************************************
    // Clock, cycle count, clock edge monitor
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // Gaps between rising shift clock edges expose any pause in a frame
    always @(posedge ref_clk) begin
        cyc++;
        if (sclk_out === 1'b1 && sclk_q === 1'b0) begin
            if (edges > 0 && cyc - last_rise > max_gap) max_gap = cyc - last_rise;
            if (edges > 0 && cyc - last_rise < min_gap) min_gap = cyc - last_rise;
            edges++;
            last_rise = cyc;
        end
        sclk_q = sclk_out;
        if (cyc == LIMIT) begin
            fail_count++;
            final_report();
        end
    end
    task automatic clr_mon();
        @(negedge ref_clk);
        edges = 0;
        max_gap = 0;
        min_gap = 99999;
    endtask : clr_mon
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report
    // ****************************************
    // APB master
    // ****************************************
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Only pready or the bench-wide cycle limit ends this wait
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] d;
        logic e;
        apb(1'b1, a, wd, d, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h0, d, e);
    endtask : rd
    function automatic logic [31:0] cw(input logic en, ms, drv, po, ph, hb, input logic [3:0] bm);
        cw = 32'h0;
        cw[BIT_EN] = en;
        cw[BIT_MS] = ms;
        cw[BIT_DRV] = drv;
        cw[BIT_PO] = po;
        cw[BIT_PH] = ph;
        cw[BIT_HB] = hb;
        cw[3:0] = bm;
    endfunction : cw
    // Mode bits are set while disabled, since enabled writes touch EN/MS/DRV only
    task automatic cfg(input logic ms, drv, po, ph, hb, input logic [3:0] bm);
        wr(OFS_CTRL, cw(1'b0, ms, drv, po, ph, hb, bm));
        wr(OFS_CTRL, cw(1'b1, ms, drv, po, ph, hb, bm));
    endtask : cfg
    task automatic wait_irq(input logic rx);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while ((rx ? rx_irq : tx_irq) !== 1'b1 && n < 2000);
        check("irq_seen", n < 2000, 1);
    endtask : wait_irq
    task automatic xfer(input logic [15:0] tw, input logic [15:0] pw, input logic [4:0] nb,
                        output logic [31:0] rx);
        peer_word <= pw;
        peer_nbits <= nb;
        peer_load <= 1'b1;
        @(posedge ref_clk);
        peer_load <= 1'b0;
        clr_mon();
        wr(OFS_TXB, {16'h0, tw});
        wait_irq(1'b1);
        rd(OFS_RXB, rx);
    endtask : xfer
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        logic [31:0] d;
        logic e;
        rd(OFS_CTRL, d);
        check("ctrl_reset", d, 32'h0);
        rd(OFS_BAUD, d);
        check("baud_reset", d, {16'h0, BAUD_RESET});
        apb(1'b0, 8'h10, 32'h0, d, e);
        check("unmapped_err", e, 1);
        check("unmapped_data", d, 32'h0);
    endtask : t_reset
    task automatic t_baud();
        logic [31:0] d;
        wr(OFS_BAUD, 32'h0000_0003);
        rd(OFS_BAUD, d);
        check("baud_reload", d, 32'h0000_0003);
        cfg(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'h7);
        repeat (2) @(posedge ref_clk);
        check("sclk_idle_high", sclk_out, 1);
        check("sclk_driven", sclk_oe, 1);
        check("master_pins", {mosi_oe, miso_oe}, 2'b10);
        rd(OFS_BAUD, d);
        check("baud_live", d[15:0] <= 16'h0003, 1);
        wr(OFS_CTRL, 32'h0);
        rd(OFS_BAUD, d);
        check("baud_kept", d, 32'h0000_0003);
    endtask : t_baud
    task automatic t_msb();
        logic [31:0] d;
        cfg(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 4'h7);
        xfer(16'h00A5, 16'h003C, 5'd8, d);
        check("rx_msb", d[7:0], 8'h3C);
        check("peer_got_msb", peer_got[7:0], 8'hA5);
        check("edges_8", edges, 8);
        check("bit_period", max_gap, 8);
        repeat (20) @(posedge ref_clk);
        check("last_bit_held", mosi_out, 1);
        rd(OFS_CTRL, d);
        check("busy_clear", d[BIT_BUSY], 0);
    endtask : t_msb
    task automatic t_lsb();
        logic [31:0] d;
        cfg(1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 4'h3);
        xfer(16'h0001, 16'h000A, 5'd4, d);
        check("rx_lsb", d[3:0], 4'h5);
        check("peer_got_lsb", peer_got[3:0], 4'h8);
        check("edges_4", edges, 4);
        check("last_bit_low", mosi_out, 0);
    endtask : t_lsb
    task automatic t_loop();
        logic [31:0] d;
        loop_sel <= 1'b1;
        cfg(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 4'hF);
        // Unselected peer sends only ones on the wired-AND line
        xfer(16'h5AC3, 16'hFFFF, 5'd16, d);
        check("self_capture", d[15:0], 16'h5AC3);
        check("edges_16", edges, 16);
        loop_sel <= 1'b0;
    endtask : t_loop
    task automatic t_b2b();
        logic [31:0] d;
        cfg(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 4'h7);
        clr_mon();
        wr(OFS_TXB, 32'h0000_0011);
        wait_irq(1'b0);
        wr(OFS_TXB, 32'h0000_0022);
        wait_irq(1'b1);
        wait_irq(1'b1);
        check("b2b_edges", edges, 16);
        check("b2b_max_gap", max_gap, 8);
        check("b2b_min_gap", min_gap, 8);
        rd(OFS_CTRL, d);
        check("b2b_busy_clear", d[BIT_BUSY], 0);
    endtask : t_b2b
    // Slave clock from the bench only within the frame, slow enough for the sync
    task automatic t_slave();
        logic [31:0] d;
        logic [7:0] seen;
        wr(OFS_CTRL, 32'h0);
        // Reload 3 stays above the slave minimum
        cfg(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 4'h7);
        wr(OFS_TXB, 32'h0000_0080);
        repeat (4) @(posedge ref_clk);
        check("slave_first_bit", miso_out, 1);
        check("slave_pins", {sclk_oe, mosi_oe, miso_oe}, 3'b001);
        rd(OFS_CTRL, d);
        check("slave_not_busy", d[BIT_BUSY], 0);
        for (int i = 7; i >= 0; i--) begin
            s_data <= SLAVE_RX[i];
            repeat (8) @(posedge ref_clk);
            seen[i] = miso_out;
            s_clk <= 1'b1;
            repeat (8) @(posedge ref_clk);
            if (i == 7) begin
                rd(OFS_CTRL, d);
                check("slave_busy", d[BIT_BUSY], 1);
            end
            s_clk <= 1'b0;
        end
        wait_irq(1'b1);
        rd(OFS_RXB, d);
        check("slave_rx", d[7:0], SLAVE_RX);
        check("slave_tx", seen, 8'h80);
    endtask : t_slave
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {psel, penable, pwrite, s_clk, s_data, loop_sel, peer_load} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        peer_word = 16'h0000;
        peer_nbits = 5'd8;
        sclk_q = 1'b0;
        sys_rst = 1'b1;
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_baud();
        t_msb();
        t_lsb();
        t_loop();
        t_b2b();
        t_slave();
        final_report();
    end
endmodule : sync_serial_master_slave_port_tb
